/* File: rtl/sdb_delay.sv */
// Safety delay block: none, on delay or off delay, evaluated once per scan.
// Assumes the input and abort nodes arrive asynchronously, and an APB master on pclk.
// Notes on behaviour
// - Three output delay types: none, off delay, on delay.
// - On delay holds output off; off delay holds it on, for the delay.
// - Delay 1 ms to 5 minutes in 1 ms steps, default 100 ms.
// - Realised delay exceeds the setting by at most one scan.
// - Each chained element adds at most one further scan.
// - Abort node exists only in off delay mode.
// - Off delay offers no cancel, cancel by input, cancel by abort node.
// - Input cancel: input returning on keeps output on, drops turn-off.
// - Node cancel: end action keeps output on or turns it off.
`timescale 1ns/1ps
module sdb_delay
   import sdb_pkg::*;
#(
   parameter int SCAN_CYC = SCAN_CYCLES
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Safety nodes
   input wire logic safety_in,
   input wire logic delay_abort_node,
   output logic safety_out
);
   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [2:0] in_sync_q;
   logic [2:0] ab_sync_q;
   logic in_f_q;
   logic ab_f_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_sync_q <= 3'h0;
         ab_sync_q <= 3'h0;
         in_f_q <= 1'b0;
         ab_f_q <= 1'b0;
      end else begin
         in_sync_q <= {in_sync_q[1:0], safety_in};
         ab_sync_q <= {ab_sync_q[1:0], delay_abort_node};
         if (in_sync_q[1] == in_sync_q[2]) begin
            in_f_q <= in_sync_q[2];
         end
         if (ab_sync_q[1] == ab_sync_q[2]) begin
            ab_f_q <= ab_sync_q[2];
         end
      end
   end
   // ****************************************
   // Scan tick
   // ****************************************
   logic [31:0] scan_cnt_q;
   logic tick_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_cnt_q <= 32'h0;
         tick_q <= 1'b0;
      end else if (scan_cnt_q == 32'(SCAN_CYC - 1)) begin
         scan_cnt_q <= 32'h0;
         tick_q <= 1'b1;
      end else begin
         scan_cnt_q <= scan_cnt_q + 32'h1;
         tick_q <= 1'b0;
      end
   end
   // ****************************************
   // Registers
   // ****************************************
   sdb_ctrl_t ctrl_q;
   logic [DLY_W-1:0] delay_q;
   logic [DLY_W-1:0] cnt_q;
   sdb_state_t st_q;
   logic out_q;
   logic acc_wr;
   logic [DLY_W-1:0] lim;
   logic abort_eff;
   logic [DLY_W-1:0] cnt_inc;
   assign acc_wr = psel && penable && pready && pwrite;
   // Out-of-range settings are clamped so the timer can never stall or run past 5 minutes.
   assign lim = (delay_q < DLY_MIN_MS) ? DLY_MIN_MS : ((delay_q > DLY_MAX_MS) ? DLY_MAX_MS : delay_q);
   assign abort_eff = ab_f_q && (ctrl_q.dtype == DT_OFF) && (ctrl_q.cancel == CN_NODE);
   assign cnt_inc = cnt_q + 19'h00001;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
         delay_q <= DLY_RST_MS;
      end else if (acc_wr && paddr == REG_CTRL) begin
         ctrl_q <= sdb_ctrl_t'(pwdata[4:0]);
      end else if (acc_wr && paddr == REG_DELAY) begin
         delay_q <= pwdata[DLY_W-1:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (psel && !penable) begin
            case (paddr)
               REG_CTRL: prdata <= {27'h0, ctrl_q};
               REG_DELAY: prdata <= {13'h0, delay_q};
               REG_STATUS: prdata <= {28'h0, ab_f_q, st_q == ST_TIMING, out_q, in_f_q};
               REG_ELAPSED: prdata <= {13'h0, cnt_q};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
   // ****************************************
   // Delay engine
   // ****************************************
   // The output changes only on scan ticks, so latency is bounded by one scan per element.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         cnt_q <= 19'h0;
         out_q <= 1'b0;
      end else if (tick_q) begin
         case (ctrl_q.dtype)
            DT_ON: begin
               if (!in_f_q) begin
                  out_q <= 1'b0;
                  st_q <= ST_IDLE;
                  cnt_q <= 19'h0;
               end else if (!out_q && st_q == ST_IDLE) begin
                  st_q <= ST_TIMING;
                  cnt_q <= 19'h0;
               end else if (st_q == ST_TIMING) begin
                  cnt_q <= cnt_inc;
                  if (cnt_inc >= lim) begin
                     out_q <= 1'b1;
                     st_q <= ST_IDLE;
                  end
               end
            end
            DT_OFF: begin
               if (st_q == ST_IDLE) begin
                  cnt_q <= 19'h0;
                  if (in_f_q) begin
                     out_q <= 1'b1;
                  end else if (out_q) begin
                     st_q <= ST_TIMING;
                  end
               end else if (ctrl_q.cancel == CN_INPUT && in_f_q) begin
                  st_q <= ST_IDLE;
                  out_q <= 1'b1;
               end else if (abort_eff) begin
                  st_q <= ST_IDLE;
                  out_q <= !ctrl_q.end_off;
               end else begin
                  cnt_q <= cnt_inc;
                  if (cnt_inc >= lim) begin
                     out_q <= 1'b0;
                     st_q <= ST_IDLE;
                  end
               end
            end
            default: begin
               out_q <= in_f_q;
               st_q <= ST_IDLE;
               cnt_q <= 19'h0;
            end
         endcase
      end
   end
   assign safety_out = out_q;
   // ****************************************
   // Checks
   // ****************************************
   AST_NONE_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_NONE |=> out_q == $past(in_f_q)) else $error("Output did not follow input.");
   AST_ON_HOLD_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_ON && !in_f_q |=> !out_q) else $error("On delay output not off.");
   AST_ON_START: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_ON && in_f_q && !out_q && st_q == ST_IDLE
      |=> !out_q && st_q == ST_TIMING && cnt_q == 19'h0) else $error("On delay did not start timing.");
   AST_ON_EXPIRE: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_ON && in_f_q && st_q == ST_TIMING && cnt_inc >= lim |=> out_q)
      else $error("On delay did not expire.");
   AST_OFF_START: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_OFF && st_q == ST_IDLE && !in_f_q && out_q
      |=> out_q && st_q == ST_TIMING && cnt_q == 19'h0) else $error("Off delay did not start timing.");
   AST_OFF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_OFF && st_q == ST_TIMING && !abort_eff && cnt_inc < lim |=> out_q)
      else $error("Off delay output dropped early.");
   AST_OFF_EXPIRE: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_OFF && st_q == ST_TIMING && !(ctrl_q.cancel == CN_INPUT && in_f_q) && !abort_eff
      && cnt_inc >= lim |=> !out_q && st_q == ST_IDLE) else $error("Off delay did not expire.");
   AST_INPUT_CANCEL: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_OFF && ctrl_q.cancel == CN_INPUT && st_q == ST_TIMING && in_f_q
      |=> out_q && st_q == ST_IDLE) else $error("Input cancel failed.");
   AST_NODE_END: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && st_q == ST_TIMING && abort_eff |=> out_q == !$past(ctrl_q.end_off))
      else $error("Abort end action wrong.");
   AST_NO_CANCEL: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_OFF && ctrl_q.cancel == CN_NONE && st_q == ST_TIMING && cnt_inc < lim
      |=> st_q == ST_TIMING) else $error("Off delay abandoned without cancel.");
   AST_NODE_ABSENT: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && ctrl_q.dtype == DT_OFF && ctrl_q.cancel != CN_NODE && st_q == ST_TIMING && !in_f_q && cnt_inc < lim
      |=> out_q && st_q == ST_TIMING) else $error("Abort node acted outside node cancel.");
   AST_OUT_ON_TICK: assert property (@(posedge pclk) disable iff (!presetn)
      out_q != $past(out_q) |-> $past(tick_q)) else $error("Output changed between scans.");
   AST_LIM_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
      lim >= DLY_MIN_MS && lim <= DLY_MAX_MS && (st_q != ST_TIMING || cnt_q < DLY_MAX_MS))
      else $error("Delay limit or count out of range.");
endmodule : sdb_delay

/* File: rtl/sdb_pkg.sv */
// Constants, register map and types of the safety delay block.
// Assumes a 40 MHz pclk and an APB master with 32-bit data.
package sdb_pkg;
   // ****************************************
   // Clock and scan timing
   // ****************************************
   localparam int CLK_HZ = 40000000;
   localparam int SCAN_TIME_US = 1000;
   localparam int SCAN_CYCLES = (CLK_HZ / 1000000) * SCAN_TIME_US;
   // ****************************************
   // Delay setting in milliseconds
   // ****************************************
   localparam int DLY_W = 19;
   localparam logic [DLY_W-1:0] DLY_MIN_MS = 19'h00001;
   localparam logic [DLY_W-1:0] DLY_MAX_MS = 19'h493e0;
   localparam logic [DLY_W-1:0] DLY_RST_MS = 19'h00064;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DELAY = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ELAPSED = 8'h0c;
   // ****************************************
   // Field positions in the control and status registers
   // ****************************************
   localparam int CTRL_TYPE_LSB = 0;
   localparam int CTRL_CANCEL_LSB = 2;
   localparam int CTRL_END_BIT = 4;
   localparam int STAT_IN_BIT = 0;
   localparam int STAT_OUT_BIT = 1;
   localparam int STAT_TIMING_BIT = 2;
   localparam int STAT_ABORT_BIT = 3;
   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {DT_NONE = 2'h0, DT_OFF = 2'h1, DT_ON = 2'h2} sdb_dtype_t;
   typedef enum logic [1:0] {CN_NONE = 2'h0, CN_INPUT = 2'h1, CN_NODE = 2'h2} sdb_cancel_t;
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_TIMING = 2'h1} sdb_state_t;
   typedef struct packed {
      logic end_off;
      sdb_cancel_t cancel;
      sdb_dtype_t dtype;
   } sdb_ctrl_t;
   localparam sdb_ctrl_t CTRL_RST = '{end_off: 1'b0, cancel: CN_NONE, dtype: DT_NONE};
endpackage : sdb_pkg

/* File: verification/sdb_partner.sv */
// Model of the logic around the delay block: an upstream stage and a downstream watcher.
// Assumes the bench sets the wanted node levels; they reach the block one edge later.
`timescale 1ns/1ps
module sdb_partner (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Wanted upstream levels
   input wire logic want_in,
   input wire logic want_abort,
   // Nodes at the block
   output logic safety_in,
   output logic delay_abort_node,
   input wire logic safety_out,
   // Downstream view
   output logic [7:0] n_fall
);
   logic out_q;
   // Counting falls catches a short off pulse that a level sample would miss.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         safety_in <= 1'b0;
         delay_abort_node <= 1'b0;
         out_q <= 1'b0;
         n_fall <= 8'h00;
      end else begin
         safety_in <= want_in;
         delay_abort_node <= want_abort;
         out_q <= safety_out;
         if (out_q && !safety_out) begin
            n_fall <= n_fall + 8'h01;
         end
      end
   end
endmodule : sdb_partner

/* File: verification/safety_delay_block_test.sv */
// Self-checking bench for the safety delay block.
// Assumes a scan shortened to SCAN cycles, so one delay step is one scan.
`timescale 1ns/1ps
module safety_delay_block_test;
   import sdb_pkg::*;
   localparam int SCAN = 8;
   localparam logic [9:0] CN = {CN_INPUT, CN_NODE, CN_NODE, CN_INPUT, CN_NONE};
   localparam logic [4:0] RET = 5'h03;
   localparam logic [4:0] AB = 5'h1c;
   localparam logic [4:0] ENDO = 5'h08;
   localparam logic [4:0] MID = 5'h17;
   localparam logic [4:0] FIN = 5'h07;
   localparam logic [4:0] NF = 5'h19;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic want_in, want_abort, safety_in, delay_abort_node, safety_out;
   logic [7:0] paddr, n_fall, f0;
   logic [31:0] pwdata, prdata, rd;
   int n_fail, tests_run, cycles;
   sdb_delay #(.SCAN_CYC(SCAN)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .safety_in(safety_in), .delay_abort_node(delay_abort_node), .safety_out(safety_out));
   sdb_partner u_far (.pclk(pclk), .presetn(presetn), .want_in(want_in), .want_abort(want_abort),
      .safety_in(safety_in), .delay_abort_node(delay_abort_node), .safety_out(safety_out), .n_fall(n_fall));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : give_verdict
   // Entered just after a rising edge; leaves one idle cycle so no signal is driven twice at once.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic scans(input int k);
      repeat (k * SCAN) @(posedge pclk);
   endtask : scans
   always @(posedge pclk) begin
      cycles++;
      if (cycles >= 5000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      {n_fail, tests_run, cycles} = '0;
      {presetn, psel, penable, pwrite, want_in, want_abort} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, REG_CTRL, 32'h0);
      check("ctrl_rst", rd, 32'h0);
      apb(1'b0, REG_DELAY, 32'h0);
      check("delay_rst", rd, 32'h64);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped_err", {31'h0, err}, 32'h1);
      check("unmapped_data", rd, 32'h0);
      apb(1'b1, REG_STATUS, 32'hf);
      apb(1'b0, REG_STATUS, 32'h0);
      check("status_ro", rd, 32'h0);
      // Type none must pass the input through and ignore the abort node.
      want_abort <= 1'b1;
      want_in <= 1'b1;
      scans(2);
      check("none_rise", safety_out, 32'h1);
      want_in <= 1'b0;
      scans(2);
      check("none_fall", safety_out, 32'h0);
      want_abort <= 1'b0;
      apb(1'b1, REG_DELAY, 32'h3);
      apb(1'b0, REG_DELAY, 32'h0);
      check("delay_rw", rd, 32'h3);
      apb(1'b1, REG_CTRL, {27'h0, 1'b0, CN_NONE, DT_ON});
      want_in <= 1'b1;
      scans(3);
      check("on_hold", safety_out, 32'h0);
      scans(2);
      check("on_rise", safety_out, 32'h1);
      apb(1'b0, REG_ELAPSED, 32'h0);
      check("on_elapsed", rd, 32'h3);
      apb(1'b0, REG_STATUS, 32'h0);
      check("on_status", rd, 32'h3);
      want_in <= 1'b0;
      scans(2);
      check("on_drop", safety_out, 32'h0);
      apb(1'b1, REG_DELAY, 32'h6);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, REG_CTRL, {27'h0, ENDO[i], CN[2*i +: 2], DT_OFF});
         want_in <= 1'b1;
         scans(2);
         check("off_on", safety_out, 32'h1);
         f0 = n_fall;
         want_in <= 1'b0;
         scans(2);
         want_in <= RET[i];
         want_abort <= AB[i];
         scans(2);
         check("off_mid", safety_out, {31'h0, MID[i]});
         scans(7);
         check("off_end", safety_out, {31'h0, FIN[i]});
         check("off_falls", n_fall - f0, {31'h0, NF[i]});
         want_in <= 1'b0;
         want_abort <= 1'b0;
         scans(10);
      end
      give_verdict();
   end
endmodule : safety_delay_block_test
